// file: hdl/itf_pkg.sv
// Package: register map, reset values and carrier types of the I2C timing/FIFO block
package itf_pkg;
    // ==============================
    // Register byte addresses
    localparam logic [31:0] ITF_SCL_HIGH_COUNT_ADR = 32'h8002080C;
    localparam logic [31:0] ITF_SCL_LOW_COUNT_ADR = 32'h80020810;
    localparam logic [31:0] ITF_OWN_SLAVE_ADDRESS_ADR = 32'h80020814;
    localparam logic [31:0] ITF_RX_FIFO_LEVEL_ADR = 32'h80020818;
    localparam logic [31:0] ITF_TX_FIFO_LEVEL_ADR = 32'h8002081C;
    localparam logic [31:0] ITF_RX_BYTE_COUNTER_ADR = 32'h80020820;
    localparam logic [31:0] ITF_TX_BYTE_COUNTER_ADR = 32'h80020824;
    localparam logic [31:0] ITF_SLAVE_TX_PORT_ADR = 32'h80020828;
    localparam logic [31:0] ITF_SLAVE_TX_FIFO_LEVEL_ADR = 32'h8002082C;

    // ==============================
    // Field widths and reset values
    localparam int ITF_CNT_W = 15;
    localparam int ITF_ADR_W = 7;
    localparam int ITF_LVL_W = 5;
    localparam int ITF_BYTE_CNT_W = 7;
    localparam int ITF_PTR_W = 4;
    localparam logic [14:0] ITF_SCL_HIGH_COUNT_RST = 15'h752E;
    localparam logic [14:0] ITF_SCL_LOW_COUNT_RST = 15'h752E;
    localparam logic [6:0] ITF_OWN_SLAVE_ADDRESS_RST = 7'h1A;
    localparam logic [4:0] ITF_FIFO_DEPTH = 5'h10;

    // ==============================
    // Types
    typedef enum logic [1:0] {
        ITF_SCL_IDLE,
        ITF_SCL_HIGH,
        ITF_SCL_LOW,
        ITF_SCL_RISE
    } itf_scl_state_type;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [31:0] adr;
        logic [31:0] dat;
    } itf_wb_req_type;

    typedef struct packed {
        logic rx_start;
        logic rx_byte;
        logic tx_start;
        logic tx_byte;
        logic st_load;
        logic st_next;
    } itf_link_evt_type;

    typedef struct packed {
        logic rx_push;
        logic rx_pop;
        logic tx_push;
        logic tx_pop;
    } itf_fifo_evt_type;
endpackage : itf_pkg

// file: hdl/itf_regs.sv
// Module: I2C timing, address, FIFO level and byte counter registers with slave transmit FIFO
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
module itf_regs (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic link_clk,
    input wire itf_pkg::itf_wb_req_type wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic master_en,
    input wire logic soft_reset,
    input wire itf_pkg::itf_fifo_evt_type fifo_evt,
    input wire logic addr_valid,
    input wire logic [6:0] addr_byte,
    output logic addr_hit,
    input wire itf_pkg::itf_link_evt_type link_evt,
    output logic link_sda_bit,
    output logic link_st_ready,
    output logic st_full,
    output logic [6:0] own_addr
);
    // ==============================
    // Clock domain state
    typedef struct packed {
        itf_pkg::itf_scl_state_type scl_st;
        logic [14:0] cnt;
        logic [14:0] hi;
        logic [14:0] lo;
        logic [6:0] adr;
        logic [4:0] rxl;
        logic [4:0] txl;
        logic [4:0] stl;
        logic [3:0] wp;
        logic [3:0] rp;
        logic [6:0] rxb;
        logic [6:0] txb;
        logic ack;
        logic [31:0] dat;
        logic scl_oe;
        logic [1:0] scl_s;
        logic [7:0] tog_s1;
        logic [3:0] tog_s2;
        logic [3:0] tog_last;
        logic [1:0] req_s;
        logic req_last;
        logic [7:0] st_data;
        logic ack_tog;
        logic addr_hit;
        logic full;
    } itf_core_type;

    // Link domain state
    typedef struct packed {
        logic [3:0] tog;
        logic req_tog;
        logic [1:0] ack_s;
        logic ack_last;
        logic [7:0] shift;
        logic loaded;
    } itf_link_type;

    itf_core_type c_r;
    itf_core_type c_nxt;
    itf_link_type l_r;
    itf_link_type l_nxt;
    logic [7:0] st_mem [16];
    logic wb_go;
    logic st_push;
    logic st_pop;
    logic [3:0] tog_chg;

    assign wb_go = wb_req.cyc && wb_req.stb && !c_r.ack;
    assign st_push = wb_go && wb_req.we && wb_req.sel[0] && !c_r.full && !soft_reset
        && wb_req.adr == itf_pkg::ITF_SLAVE_TX_PORT_ADR;
    assign st_pop = (c_r.req_s[1] != c_r.req_last) && c_r.stl != 5'h00 && !soft_reset;
    assign tog_chg = c_r.tog_s2 ^ c_r.tog_last;

    // ==============================
    // Core domain next state
    always_comb begin
        c_nxt = c_r;
        c_nxt.ack = wb_go;
        c_nxt.scl_s = {c_r.scl_s[0], scl_i};
        c_nxt.tog_s1 = {c_r.tog_s1[3:0], l_r.tog};
        c_nxt.tog_s2 = c_r.tog_s1[7:4];
        c_nxt.tog_last = c_r.tog_s2;
        c_nxt.req_s = {c_r.req_s[0], l_r.req_tog};
        // Register access; reserved bits read as zero
        c_nxt.dat = 32'h00000000;
        if (wb_go && !wb_req.we) begin
            case (wb_req.adr)
                itf_pkg::ITF_SCL_HIGH_COUNT_ADR: c_nxt.dat = {17'h00000, c_r.hi};
                itf_pkg::ITF_SCL_LOW_COUNT_ADR: c_nxt.dat = {17'h00000, c_r.lo};
                itf_pkg::ITF_OWN_SLAVE_ADDRESS_ADR: c_nxt.dat = {25'h0000000, c_r.adr};
                itf_pkg::ITF_RX_FIFO_LEVEL_ADR: c_nxt.dat = {27'h0000000, c_r.rxl};
                itf_pkg::ITF_TX_FIFO_LEVEL_ADR: c_nxt.dat = {27'h0000000, c_r.txl};
                itf_pkg::ITF_RX_BYTE_COUNTER_ADR: c_nxt.dat = {25'h0000000, c_r.rxb};
                itf_pkg::ITF_TX_BYTE_COUNTER_ADR: c_nxt.dat = {25'h0000000, c_r.txb};
                itf_pkg::ITF_SLAVE_TX_FIFO_LEVEL_ADR: c_nxt.dat = {27'h0000000, c_r.stl};
                default: c_nxt.dat = 32'h00000000;
            endcase
        end
        // Byte lanes 0 and 1 cover every writable field
        if (wb_go && wb_req.we) begin
            case (wb_req.adr)
                itf_pkg::ITF_SCL_HIGH_COUNT_ADR: begin
                    if (wb_req.sel[0]) c_nxt.hi[7:0] = wb_req.dat[7:0];
                    if (wb_req.sel[1]) c_nxt.hi[14:8] = wb_req.dat[14:8];
                end
                itf_pkg::ITF_SCL_LOW_COUNT_ADR: begin
                    if (wb_req.sel[0]) c_nxt.lo[7:0] = wb_req.dat[7:0];
                    if (wb_req.sel[1]) c_nxt.lo[14:8] = wb_req.dat[14:8];
                end
                itf_pkg::ITF_OWN_SLAVE_ADDRESS_ADR: begin
                    if (wb_req.sel[0]) c_nxt.adr = wb_req.dat[6:0];
                end
                default: begin
                end
            endcase
        end
        // FIFO levels follow pushes and pops one cycle later
        if (fifo_evt.rx_push && !fifo_evt.rx_pop && c_r.rxl != itf_pkg::ITF_FIFO_DEPTH) begin
            c_nxt.rxl = c_r.rxl + 5'h01;
        end else if (fifo_evt.rx_pop && !fifo_evt.rx_push && c_r.rxl != 5'h00) begin
            c_nxt.rxl = c_r.rxl - 5'h01;
        end
        if (fifo_evt.tx_push && !fifo_evt.tx_pop && c_r.txl != itf_pkg::ITF_FIFO_DEPTH) begin
            c_nxt.txl = c_r.txl + 5'h01;
        end else if (fifo_evt.tx_pop && !fifo_evt.tx_push && c_r.txl != 5'h00) begin
            c_nxt.txl = c_r.txl - 5'h01;
        end
        if (st_push) begin
            c_nxt.wp = c_r.wp + 4'h1;
        end
        if (st_pop) begin
            c_nxt.rp = c_r.rp + 4'h1;
            c_nxt.st_data = st_mem[c_r.rp];
            c_nxt.ack_tog = !c_r.ack_tog;
        end
        // A request is only retired once a byte answers it
        if (st_pop || c_r.stl == 5'h00 && c_r.req_s[1] == c_r.req_last) begin
            c_nxt.req_last = c_r.req_s[1];
        end
        if (st_push && !st_pop) begin
            c_nxt.stl = c_r.stl + 5'h01;
        end else if (st_pop && !st_push) begin
            c_nxt.stl = c_r.stl - 5'h01;
        end
        c_nxt.full = c_nxt.stl == itf_pkg::ITF_FIFO_DEPTH;
        // Byte counters; 7-bit sum wraps on its own
        if (tog_chg[0]) begin
            c_nxt.rxb = 7'h00;
        end
        if (tog_chg[1]) begin
            c_nxt.rxb = c_nxt.rxb + 7'h01;
        end
        if (tog_chg[2]) begin
            c_nxt.txb = 7'h00;
        end
        if (tog_chg[3]) begin
            c_nxt.txb = c_nxt.txb + 7'h01;
        end
        if (addr_valid) begin
            c_nxt.addr_hit = !master_en && addr_byte == c_r.adr;
        end
        // SCL timing
        case (c_r.scl_st)
            itf_pkg::ITF_SCL_IDLE: begin
                c_nxt.scl_oe = 1'b0;
                c_nxt.cnt = 15'h0000;
                if (master_en && c_r.scl_s[1]) begin
                    c_nxt.scl_st = itf_pkg::ITF_SCL_HIGH;
                end
            end
            itf_pkg::ITF_SCL_HIGH: begin
                c_nxt.cnt = c_r.cnt + 15'h0001;
                if (!c_r.scl_s[1]) begin
                    c_nxt.scl_st = itf_pkg::ITF_SCL_LOW;
                    c_nxt.scl_oe = 1'b1;
                    c_nxt.cnt = 15'h0000;
                end else if (c_nxt.cnt >= c_r.hi) begin
                    c_nxt.scl_st = itf_pkg::ITF_SCL_LOW;
                    c_nxt.scl_oe = 1'b1;
                    c_nxt.cnt = 15'h0000;
                end
            end
            itf_pkg::ITF_SCL_LOW: begin
                // Counting waits for the line to be seen low through the synchroniser
                if (!c_r.scl_s[1]) begin
                    c_nxt.cnt = c_r.cnt + 15'h0001;
                    if (c_nxt.cnt >= c_r.lo) begin
                        c_nxt.scl_st = itf_pkg::ITF_SCL_RISE;
                        c_nxt.scl_oe = 1'b0;
                        c_nxt.cnt = 15'h0000;
                    end
                end
            end
            itf_pkg::ITF_SCL_RISE: begin
                // Slaves may stretch the low phase here
                if (c_r.scl_s[1]) begin
                    c_nxt.scl_st = itf_pkg::ITF_SCL_HIGH;
                end
            end
            default: begin
                c_nxt.scl_st = itf_pkg::ITF_SCL_IDLE;
            end
        endcase
        if (!master_en) begin
            c_nxt.scl_st = itf_pkg::ITF_SCL_IDLE;
            c_nxt.scl_oe = 1'b0;
        end
        if (soft_reset) begin
            c_nxt.scl_st = itf_pkg::ITF_SCL_IDLE;
            c_nxt.scl_oe = 1'b0;
            c_nxt.cnt = 15'h0000;
            c_nxt.rxl = 5'h00;
            c_nxt.txl = 5'h00;
            c_nxt.stl = 5'h00;
            c_nxt.wp = 4'h0;
            c_nxt.rp = 4'h0;
            c_nxt.full = 1'b0;
            c_nxt.rxb = 7'h00;
            c_nxt.txb = 7'h00;
            c_nxt.addr_hit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            c_r <= '0;
            c_r.scl_st <= itf_pkg::ITF_SCL_IDLE;
            c_r.hi <= itf_pkg::ITF_SCL_HIGH_COUNT_RST;
            c_r.lo <= itf_pkg::ITF_SCL_LOW_COUNT_RST;
            c_r.adr <= itf_pkg::ITF_OWN_SLAVE_ADDRESS_RST;
            c_r.scl_s <= 2'h3;
        end else begin
            c_r <= c_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (st_push) begin
            st_mem[c_r.wp] <= wb_req.dat[7:0];
        end
    end

    // ==============================
    // Link domain: events become toggles, slave byte shifter
    always_comb begin
        l_nxt = l_r;
        l_nxt.tog = l_r.tog ^ {link_evt.tx_byte, link_evt.tx_start,
            link_evt.rx_byte, link_evt.rx_start};
        l_nxt.ack_s = {l_r.ack_s[0], c_r.ack_tog};
        if (link_evt.st_load) begin
            l_nxt.req_tog = !l_r.req_tog;
            l_nxt.loaded = 1'b0;
        end else if (l_r.ack_s[1] != l_r.ack_last) begin
            // Byte is stable in the core domain once its toggle is seen
            l_nxt.ack_last = l_r.ack_s[1];
            l_nxt.shift = c_r.st_data;
            l_nxt.loaded = 1'b1;
        end else if (link_evt.st_next) begin
            l_nxt.shift = {l_r.shift[6:0], 1'b0};
        end
    end

    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    assign wb_dat_o = c_r.dat;
    assign wb_ack_o = c_r.ack;
    assign scl_o = 1'b0 & c_r.scl_oe;
    assign scl_oe = c_r.scl_oe;
    assign addr_hit = c_r.addr_hit;
    assign st_full = c_r.full;
    assign own_addr = c_r.adr;
    assign link_sda_bit = l_r.shift[7];
    assign link_st_ready = l_r.loaded;

    // ==============================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_high_wait;
        $rose(c_r.scl_oe) && $past(c_r.scl_st) == itf_pkg::ITF_SCL_HIGH && $past(c_r.scl_s[1])
            |-> $past(c_r.cnt) + 15'h0001 >= $past(c_r.hi);
    endproperty
    a_high_wait: assert property (p_high_wait) else $error("SCL driven low before high count");

    property p_abort;
        c_r.scl_st == itf_pkg::ITF_SCL_HIGH && !c_r.scl_s[1] && master_en && !soft_reset
            |=> c_r.scl_oe && c_r.scl_st == itf_pkg::ITF_SCL_LOW;
    endproperty
    a_abort: assert property (p_abort) else $error("High wait not abandoned on low SCL");

    property p_low_wait;
        $fell(c_r.scl_oe) && master_en && !$past(soft_reset)
            |-> $past(c_r.cnt) + 15'h0001 >= $past(c_r.lo);
    endproperty
    a_low_wait: assert property (p_low_wait) else $error("SCL released before low count");

    property p_addr_match;
        addr_valid && master_en && !soft_reset |=> !c_r.addr_hit;
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("Address hit in master mode");

    property p_rx_level;
        fifo_evt.rx_push && !fifo_evt.rx_pop && !soft_reset && c_r.rxl < 5'h10
            |=> c_r.rxl == $past(c_r.rxl) + 5'h01;
    endproperty
    a_rx_level: assert property (p_rx_level) else $error("Receive level did not follow push");

    property p_tx_cap;
        c_r.txl <= itf_pkg::ITF_FIFO_DEPTH && c_r.stl <= itf_pkg::ITF_FIFO_DEPTH;
    endproperty
    a_tx_cap: assert property (p_tx_cap) else $error("FIFO level above sixteen");

    property p_rx_wrap;
        tog_chg[1] && !tog_chg[0] && c_r.rxb == 7'h7F && !soft_reset |=> c_r.rxb == 7'h00;
    endproperty
    a_rx_wrap: assert property (p_rx_wrap) else $error("Receive counter did not wrap");

    property p_tx_clear;
        tog_chg[2] && !tog_chg[3] && !soft_reset |=> c_r.txb == 7'h00;
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("Sent counter not cleared");

    // A pop or flush right after the push may legally empty the FIFO again
    property p_st_push;
        st_push && !st_pop |=> c_r.stl == $past(c_r.stl) + 5'h01
            ##1 (c_r.stl != 5'h00 || $past(st_pop) || $past(soft_reset));
    endproperty
    a_st_push: assert property (p_st_push) else $error("Slave FIFO push lost");

    property p_soft_reset;
        soft_reset |=> c_r.stl == 5'h00 && c_r.rxl == 5'h00 && c_r.hi == $past(c_r.hi)
            && c_r.adr == $past(c_r.adr);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("Soft reset effect wrong");

    property p_tx_wrap;
        tog_chg[3] && !tog_chg[2] && c_r.txb == 7'h7F && !soft_reset |=> c_r.txb == 7'h00;
    endproperty
    a_tx_wrap: assert property (p_tx_wrap) else $error("Sent counter did not wrap");

    // Shifter lives on the link clock, so this one names its own clock
    property p_msb_first;
        @(posedge link_clk) disable iff (!rst_b)
            link_evt.st_next && !link_evt.st_load && l_r.ack_s[1] == l_r.ack_last
            |=> l_r.shift == {$past(l_r.shift[6:0]), 1'b0};
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("Slave byte not sent MSB first");
endmodule : itf_regs

// file: sim/itf_partner.sv
// Far side of the block: SCL wire with pull-up, another master, link clock and link events
`timescale 1ns/1ps
module itf_partner (
    input wire logic scl_oe,
    input wire logic pull_low,
    input wire logic frame_on,
    output logic scl_i,
    output logic link_clk,
    output itf_pkg::itf_link_evt_type link_evt
);
    // ==========================================
    // Wire level
    // Open drain with pull-up: any party pulling low wins
    assign scl_i = ~(scl_oe | pull_low);

    // ==========================================
    // Link clock
    initial begin
        link_clk = 1'b0;
        link_evt = '0;
        #7;
        // Stands still between frames, phase unrelated to the core clock
        forever begin
            #15;
            link_clk = frame_on ? ~link_clk : 1'b0;
        end
    end

    // One link cycle wide event, launched just after a link edge
    task automatic pulse(input itf_pkg::itf_link_evt_type e);
        @(posedge link_clk);
        link_evt <= e;
        @(posedge link_clk);
        link_evt <= '0;
    endtask : pulse
endmodule : itf_partner

// file: sim/test_itf_regs.sv
// Self-checking testbench of the I2C timing, level and counter registers
`timescale 1ns/1ps
module test_itf_regs;
    typedef struct {logic rd; logic [31:0] val; string nm;} itf_exp_type;
    localparam logic [31:0] hi_a = itf_pkg::ITF_SCL_HIGH_COUNT_ADR;
    localparam logic [31:0] lo_a = itf_pkg::ITF_SCL_LOW_COUNT_ADR;
    localparam logic [31:0] own_a = itf_pkg::ITF_OWN_SLAVE_ADDRESS_ADR;
    localparam logic [31:0] rxl_a = itf_pkg::ITF_RX_FIFO_LEVEL_ADR;
    localparam logic [31:0] txl_a = itf_pkg::ITF_TX_FIFO_LEVEL_ADR;
    localparam logic [31:0] rxb_a = itf_pkg::ITF_RX_BYTE_COUNTER_ADR;
    localparam logic [31:0] stx_a = itf_pkg::ITF_SLAVE_TX_PORT_ADR;
    localparam logic [31:0] stl_a = itf_pkg::ITF_SLAVE_TX_FIFO_LEVEL_ADR;
    logic clk, rst_b, master_en, soft_reset, addr_valid, pull_low, frame_on;
    logic [6:0] addr_byte, own_addr, own_v;
    itf_pkg::itf_wb_req_type wb_req;
    itf_pkg::itf_fifo_evt_type fifo_evt;
    itf_pkg::itf_link_evt_type link_evt;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, scl_i, scl_o, scl_oe, link_clk, link_sda_bit, link_st_ready, st_full;
    logic addr_hit;
    int failures = 0;
    int tests_run = 0;
    int n;
    integer seed = 32'h857E773C;
    logic [7:0] sb [16];
    itf_exp_type exp_q [$];
    itf_exp_type note;

    itf_regs uut (.clk(clk), .rst_b(rst_b), .link_clk(link_clk), .wb_req(wb_req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i), .scl_o(scl_o),
        .scl_oe(scl_oe), .master_en(master_en), .soft_reset(soft_reset),
        .fifo_evt(fifo_evt), .addr_valid(addr_valid), .addr_byte(addr_byte),
        .addr_hit(addr_hit), .link_evt(link_evt), .link_sda_bit(link_sda_bit),
        .link_st_ready(link_st_ready), .st_full(st_full), .own_addr(own_addr));
    itf_partner far (.scl_oe(scl_oe), .pull_low(pull_low), .frame_on(frame_on),
        .scl_i(scl_i), .link_clk(link_clk), .link_evt(link_evt));

    // ==========================================
    // Helpers
    task automatic results();
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask : chk

    // Classic single cycle; the read expectation goes to the monitor's queue
    task automatic bus(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                       input logic [31:0] e, input string nm);
        int k;
        exp_q.push_back('{~we, e, nm});
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, we, 4'hF, adr, dat};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        wb_req <= '0;
        if (k >= 20) begin
            failures++;
            results();
        end
    endtask : bus

    always @(posedge clk) begin
        if (wb_ack_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("spurious_ack", 32'h0, 32'h1);
            end else begin
                note = exp_q.pop_front();
                if (note.rd) begin
                    chk(note.nm, note.val, wb_dat_o);
                end
            end
        end
    end

    task automatic fev(input logic [3:0] v, input int cnt);
        repeat (cnt) begin
            @(posedge clk);
            fifo_evt <= itf_pkg::itf_fifo_evt_type'(v);
            @(posedge clk);
            fifo_evt <= '0;
        end
    endtask : fev

    task automatic lev(input logic [5:0] v);
        far.pulse(itf_pkg::itf_link_evt_type'(v));
    endtask : lev

    task automatic hit(input logic [6:0] a, input logic e);
        @(posedge clk);
        addr_valid <= 1'b1;
        addr_byte <= a;
        @(posedge clk);
        addr_valid <= 1'b0;
        @(negedge clk);
        chk("addr_hit", {31'h0, e}, {31'h0, addr_hit});
    endtask : hit

    // Bounded wait for the SCL drive to reach a level, counting cycles
    task automatic oe_wait(input logic v, output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (scl_oe !== v && k < 300);
        if (k >= 300) begin
            failures++;
            results();
        end
    endtask : oe_wait

    // ==========================================
    // Clock, reset and watchdog
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        #2000000;
        failures++;
        results();
    end

    // ==========================================
    // Main sequence
    initial begin
        rst_b = 1'b0;
        master_en = 1'b0;
        soft_reset = 1'b0;
        addr_valid = 1'b0;
        addr_byte = 7'h00;
        pull_low = 1'b0;
        frame_on = 1'b0;
        wb_req = '0;
        fifo_evt = '0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b0, hi_a, 32'h0, 32'h0000752E, "scl_high_count");
        bus(1'b0, lo_a, 32'h0, 32'h0000752E, "scl_low_count");
        bus(1'b0, own_a, 32'h0, 32'h0000001A, "own_slave_address");
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, rxl_a + 32'(4 * i), 32'h0, 32'h0, "level_or_count");
        end
        bus(1'b0, stl_a, 32'h0, 32'h0, "slave_tx_fifo_level");
        bus(1'b0, 32'h80020830, 32'h0, 32'h0, "unmapped");
        bus(1'b1, txl_a, 32'h0000001F, 32'h0, "wr");
        bus(1'b0, txl_a, 32'h0, 32'h0, "tx_fifo_level");
        own_v = 7'($random(seed));
        bus(1'b1, own_a, {25'h0, own_v}, 32'h0, "wr");
        bus(1'b0, own_a, 32'h0, {25'h0, own_v}, "own_slave_address");
        chk("own_addr", {25'h0, own_v}, {25'h0, own_addr});
        hit(own_v, 1'b1);
        hit(~own_v, 1'b0);
        fev(4'h8, 3);
        fev(4'h4, 1);
        bus(1'b0, rxl_a, 32'h0, 32'h2, "rx_fifo_level");
        fev(4'h2, 17);
        bus(1'b0, txl_a, 32'h0, 32'h10, "tx_fifo_level");
        for (int i = 0; i < 16; i++) begin
            sb[i] = 8'($random(seed));
            bus(1'b1, stx_a, {24'h0, sb[i]}, 32'h0, "wr");
        end
        @(negedge clk);
        chk("st_full", 32'h1, {31'h0, st_full});
        // Writer never pushes into a full slave FIFO
        if (st_full !== 1'b1) begin
            bus(1'b1, stx_a, 32'h000000A5, 32'h0, "wr");
        end
        bus(1'b0, stl_a, 32'h0, 32'h10, "slave_tx_fifo_level");
        // Link traffic; clock runs only inside this frame
        frame_on <= 1'b1;
        lev(6'h02);
        for (n = 0; n < 60 && link_st_ready !== 1'b1; n++) @(posedge clk);
        chk("link_st_ready", 32'h1, {31'h0, link_st_ready});
        for (int b = 7; b >= 0; b--) begin
            @(negedge link_clk);
            chk("link_sda_bit", {31'h0, sb[0][b]}, {31'h0, link_sda_bit});
            lev(6'h01);
        end
        bus(1'b0, stl_a, 32'h0, 32'hF, "slave_tx_fifo_level");
        // Receive counter past 127, then send counter past 127
        for (int s = 0; s < 2; s++) begin
            lev(s == 0 ? 6'h20 : 6'h08);
            repeat (130 - s) begin
                lev(s == 0 ? 6'h10 : 6'h04);
                repeat (4) @(posedge clk);
            end
            repeat (8) @(posedge clk);
            bus(1'b0, rxb_a + 32'(4 * s), 32'h0, 32'(2 - s), "byte_counter");
            lev(s == 0 ? 6'h20 : 6'h08);
            repeat (8) @(posedge clk);
            bus(1'b0, rxb_a + 32'(4 * s), 32'h0, 32'h0, "byte_counter");
        end
        frame_on <= 1'b0;
        // SCL timing: high 20, low 4
        bus(1'b1, hi_a, 32'h00000014, 32'h0, "wr");
        bus(1'b1, lo_a, 32'h00000004, 32'h0, "wr");
        master_en <= 1'b1;
        hit(own_v, 1'b0);
        oe_wait(1'b1, n);
        chk("scl_o", 32'h0, {31'h0, scl_o});
        oe_wait(1'b0, n);
        chk("scl_low_time", 32'h1, 32'(n >= 4 && n <= 8));
        oe_wait(1'b1, n);
        chk("scl_high_time", 32'h1, 32'(n >= 20 && n <= 26));
        oe_wait(1'b0, n);
        repeat (5) @(posedge clk);
        pull_low <= 1'b1;
        oe_wait(1'b1, n);
        chk("scl_abort", 32'h1, 32'(n <= 5));
        pull_low <= 1'b0;
        master_en <= 1'b0;
        // Soft reset keeps divisors and address
        fev(4'h8, 2);
        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        bus(1'b0, rxl_a, 32'h0, 32'h0, "rx_fifo_level");
        bus(1'b0, stl_a, 32'h0, 32'h0, "slave_tx_fifo_level");
        bus(1'b0, hi_a, 32'h0, 32'h14, "scl_high_count");
        bus(1'b0, own_a, 32'h0, {25'h0, own_v}, "own_slave_address");
        repeat (3) @(posedge clk);
        results();
    end
endmodule : test_itf_regs
